/* plpmr_regs.sv */
// What this block does
// - First mask: bits 7,6,5,4,3,2,0 mask limits, clamps, undervoltages, cap error; reset 1.
// - Second mask: bits 7,6,5,4,3,1 mask temperature, fail, good, done, overrun; reset 1.
// - High switch limit is a 5-bit code, reset 01011 for 2A.
// - Low switch limit is its own 5-bit code, same encoding, reset 01011.
// - Buck release stops when storage falls below the 8-bit threshold, reset 0x37.
// - Deep test discharge time captured read-only, resets to zero.
// - Turn-on policy bit 6: 1 waits for both inputs good, 0 independent.
// - Sharing bit 5: 0 buck mode, 1 boost sharing mode; reset 0.
// - Restart bit 3: 0 auto re-enable after overrun, 1 waits for an enable toggle.
// - Discharge bit 2: FET on in forced test, or also when charging disabled.
// - Storage voltage at deep test start captured read-only, resets to zero.
// - Initial forced voltage copied after first forced test and control bit rises.
// - Final forced voltage copied under the same two triggers.
// - Sharing buck feedback reference defaults 0.6V, programmable 400mV to 1.27V.
// - Overrun flag sets when release time exceeds the maximum backup timer.
// - First interrupt reflects limit, clamp, undervoltage and cap error conditions.
`timescale 1ns/100ps
`include "plpmr_defs.svh"

module plpmr_regs
  import plpmr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `PLPMR_SLAVE_ADDR
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two,
  input wire logic forced_test_active,
  input wire logic forced_test_done,
  input wire logic [7:0] forced_start_voltage,
  input wire logic [7:0] forced_final_voltage,
  input wire logic capture_ctrl_bit,
  input wire logic deep_test_start,
  input wire logic deep_test_end,
  input wire logic [7:0] deep_test_timer,
  input wire logic [7:0] storage_voltage_code,
  input wire logic high_input_ok,
  input wire logic low_input_ok,
  input wire logic high_switch_enable_bit,
  input wire logic low_switch_enable_bit,
  input wire logic enable_pin,
  input wire logic charge_enable_bit,
  input wire logic [7:0] release_time,
  input wire logic [7:0] max_backup_release_timer,
  input wire logic storage_at_uvlo,
  output logic first_interrupt_output_b,
  output logic second_interrupt_output_b,
  output logic high_switch_on,
  output logic low_switch_on,
  output logic sharing_boost_mode,
  output logic discharge_fet_on,
  output logic release_stop,
  output logic release_overrun_flag,
  output logic [4:0] high_current_limit_code,
  output logic [4:0] low_current_limit_code,
  output logic [7:0] buck_feedback_ref_code
);

  logic scl_m_r, scl_s_r, scl_q_r;
  logic sda_m_r, sda_s_r, sda_q_r;
  logic pin_m_r, pin_s_r, pin_q_r;
  logic start_det, stop_det, scl_rise, scl_fall;
  plpmr_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data;
  logic [7:0] mask_one_r, mask_two_r;
  logic [4:0] high_limit_r, low_limit_r;
  logic [7:0] rls_uv_r, sys_two_r, fb_ref_r;
  logic [7:0] deep_time_r, deep_start_r, stored_init_r, stored_final_r;
  logic first_forced_seen_r;
  logic capture_q_r;
  logic high_en_q_r, low_en_q_r;
  logic enable_toggle;
  logic overrun_set;

  // Pins cross in through two stages; edges are taken from stage two on
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_q_r <= 1'b1;
      pin_m_r <= 1'b0;
      pin_s_r <= 1'b0;
      pin_q_r <= 1'b0;
    end
    else
    begin
      scl_m_r <= i2c_scl;
      scl_s_r <= scl_m_r;
      scl_q_r <= scl_s_r;
      sda_m_r <= i2c_sda_in;
      sda_s_r <= sda_m_r;
      sda_q_r <= sda_s_r;
      pin_m_r <= enable_pin;
      pin_s_r <= pin_m_r;
      pin_q_r <= pin_s_r;
    end
  end

  assign start_det = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
  assign scl_rise = scl_s_r & ~scl_q_r;
  assign scl_fall = ~scl_s_r & scl_q_r;

  always_comb
  begin
    case (ptr_r)
      `PLPMR_OFS_MASK_ONE: rd_data = mask_one_r;
      `PLPMR_OFS_MASK_TWO: rd_data = mask_two_r;
      `PLPMR_OFS_HIGH_LIMIT: rd_data = {3'h0, high_limit_r};
      `PLPMR_OFS_LOW_LIMIT: rd_data = {3'h0, low_limit_r};
      `PLPMR_OFS_RLS_UV: rd_data = rls_uv_r;
      `PLPMR_OFS_DEEP_TIME: rd_data = deep_time_r;
      `PLPMR_OFS_SYS_TWO: rd_data = sys_two_r;
      `PLPMR_OFS_FB_REF: rd_data = fb_ref_r;
      `PLPMR_OFS_DEEP_START: rd_data = deep_start_r;
      `PLPMR_OFS_STORED_INIT: rd_data = stored_init_r;
      `PLPMR_OFS_STORED_FINAL: rd_data = stored_final_r;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial slave: sample on SCL rise, change SDA on SCL fall
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= PLPMR_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      i2c_sda_oe <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end
    else
    begin
      wr_stb_r <= 1'b0;
      if (start_det)
      begin
        state_r <= PLPMR_ADDR;
        cnt_r <= 4'h0;
        i2c_sda_oe <= 1'b0;
      end
      else if (stop_det)
      begin
        state_r <= PLPMR_IDLE;
        i2c_sda_oe <= 1'b0;
      end
      else
      begin
        case (state_r)
          PLPMR_ADDR, PLPMR_PTR, PLPMR_WR:
          begin
            if (scl_rise && cnt_r != `PLPMR_BYTE_BITS)
            begin
              sh_r <= {sh_r[6:0], sda_s_r};
              cnt_r <= cnt_r + 4'h1;
            end
            else if (scl_fall && cnt_r == `PLPMR_BYTE_BITS)
            begin
              cnt_r <= 4'h0;
              i2c_sda_oe <= 1'b1;
              if (state_r == PLPMR_ADDR)
              begin
                if (sh_r[7:1] == SLAVE_ADDR)
                begin
                  rw_r <= sh_r[0];
                  state_r <= PLPMR_ACK_ADDR;
                end
                else
                begin
                  // Another device's address: stay off the bus till next start
                  i2c_sda_oe <= 1'b0;
                  state_r <= PLPMR_IDLE;
                end
              end
              else if (state_r == PLPMR_PTR)
              begin
                ptr_r <= sh_r;
                state_r <= PLPMR_ACK_PTR;
              end
              else
              begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= sh_r;
                state_r <= PLPMR_ACK_WR;
              end
            end
          end
          PLPMR_ACK_ADDR:
          begin
            if (scl_fall)
            begin
              if (rw_r)
              begin
                i2c_sda_oe <= ~rd_data[7];
                sh_r <= {rd_data[6:0], 1'b0};
                cnt_r <= 4'h1;
                state_r <= PLPMR_RD;
              end
              else
              begin
                i2c_sda_oe <= 1'b0;
                state_r <= PLPMR_PTR;
              end
            end
          end
          PLPMR_ACK_PTR, PLPMR_ACK_WR:
          begin
            if (scl_fall)
            begin
              i2c_sda_oe <= 1'b0;
              if (state_r == PLPMR_ACK_WR)
              begin
                ptr_r <= ptr_r + 8'h01;
              end
              state_r <= PLPMR_WR;
            end
          end
          PLPMR_RD:
          begin
            if (scl_fall)
            begin
              if (cnt_r != `PLPMR_BYTE_BITS)
              begin
                i2c_sda_oe <= ~sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end
              else
              begin
                i2c_sda_oe <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
                state_r <= PLPMR_RD_ACK;
              end
            end
          end
          PLPMR_RD_ACK:
          begin
            if (scl_rise)
            begin
              state_r <= sda_s_r ? PLPMR_IDLE : PLPMR_RD_NEXT;
            end
          end
          PLPMR_RD_NEXT:
          begin
            if (scl_fall)
            begin
              i2c_sda_oe <= ~rd_data[7];
              sh_r <= {rd_data[6:0], 1'b0};
              cnt_r <= 4'h1;
              state_r <= PLPMR_RD;
            end
          end
          default:
          begin
            i2c_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      i2c_sda_out <= 1'b0;
    end
    else
    begin
      i2c_sda_out <= 1'b0;
    end
  end

  // Host-writable configuration; reserved bits stay zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_one_r <= `PLPMR_MASK_ONE_RST;
      mask_two_r <= `PLPMR_MASK_TWO_RST;
      high_limit_r <= `PLPMR_LIMIT_RST;
      low_limit_r <= `PLPMR_LIMIT_RST;
      rls_uv_r <= `PLPMR_RLS_UV_RST;
      sys_two_r <= `PLPMR_SYS_TWO_RST;
      fb_ref_r <= `PLPMR_FB_REF_RST;
    end
    else if (wr_stb_r)
    begin
      case (wr_addr_r)
        `PLPMR_OFS_MASK_ONE: mask_one_r <= wr_data_r & `PLPMR_MASK_ONE_BITS;
        `PLPMR_OFS_MASK_TWO: mask_two_r <= wr_data_r & `PLPMR_MASK_TWO_BITS;
        `PLPMR_OFS_HIGH_LIMIT: high_limit_r <= wr_data_r[4:0];
        `PLPMR_OFS_LOW_LIMIT: low_limit_r <= wr_data_r[4:0];
        // Codes outside the documented span are pinned to its ends
        `PLPMR_OFS_RLS_UV:
          rls_uv_r <= (wr_data_r < `PLPMR_RLS_UV_MIN) ? `PLPMR_RLS_UV_MIN :
                      (wr_data_r > `PLPMR_RLS_UV_MAX) ? `PLPMR_RLS_UV_MAX : wr_data_r;
        `PLPMR_OFS_SYS_TWO: sys_two_r <= wr_data_r & `PLPMR_SYS_TWO_BITS;
        `PLPMR_OFS_FB_REF:
          fb_ref_r <= (wr_data_r > `PLPMR_FB_REF_MAX) ? `PLPMR_FB_REF_MAX : wr_data_r;
        default: ;
      endcase
    end
  end

  // Read-only captures from the test sequencer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      deep_time_r <= `PLPMR_CAPT_RST;
      deep_start_r <= `PLPMR_CAPT_RST;
      stored_init_r <= `PLPMR_CAPT_RST;
      stored_final_r <= `PLPMR_CAPT_RST;
      first_forced_seen_r <= 1'b0;
      capture_q_r <= 1'b0;
    end
    else
    begin
      capture_q_r <= capture_ctrl_bit;
      if (deep_test_end)
      begin
        deep_time_r <= deep_test_timer;
      end
      if (deep_test_start)
      begin
        deep_start_r <= storage_voltage_code;
      end
      if (forced_test_done)
      begin
        first_forced_seen_r <= 1'b1;
      end
      // Only the very first forced test auto-copies; later ones need the control edge
      if ((forced_test_done && !first_forced_seen_r) || (capture_ctrl_bit && !capture_q_r))
      begin
        stored_init_r <= forced_start_voltage;
        stored_final_r <= forced_final_voltage;
      end
    end
  end

  assign enable_toggle = (high_switch_enable_bit ^ high_en_q_r) |
                         (low_switch_enable_bit ^ low_en_q_r) | (pin_s_r ^ pin_q_r);
  assign overrun_set = release_time > max_backup_release_timer;

  // Overrun flag holds the switches off until the restart policy lets go
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      release_overrun_flag <= 1'b0;
      high_en_q_r <= 1'b0;
      low_en_q_r <= 1'b0;
    end
    else
    begin
      high_en_q_r <= high_switch_enable_bit;
      low_en_q_r <= low_switch_enable_bit;
      if (overrun_set)
      begin
        release_overrun_flag <= 1'b1;
      end
      else if (release_overrun_flag && storage_at_uvlo && (high_input_ok || low_input_ok))
      begin
        if (!sys_two_r[`PLPMR_BIT_RESTART] || enable_toggle)
        begin
          release_overrun_flag <= 1'b0;
        end
      end
    end
  end

  // Control outputs
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      high_switch_on <= 1'b0;
      low_switch_on <= 1'b0;
      sharing_boost_mode <= 1'b0;
      discharge_fet_on <= 1'b0;
      release_stop <= 1'b0;
      first_interrupt_output_b <= 1'b1;
      second_interrupt_output_b <= 1'b1;
      high_current_limit_code <= `PLPMR_LIMIT_RST;
      low_current_limit_code <= `PLPMR_LIMIT_RST;
      buck_feedback_ref_code <= `PLPMR_FB_REF_RST;
    end
    else
    begin
      if (sys_two_r[`PLPMR_BIT_ONTOGETHER])
      begin
        high_switch_on <= high_switch_enable_bit & pin_s_r & ~release_overrun_flag &
                          high_input_ok & low_input_ok;
        low_switch_on <= low_switch_enable_bit & pin_s_r & ~release_overrun_flag &
                         high_input_ok & low_input_ok;
      end
      else
      begin
        high_switch_on <= high_switch_enable_bit & pin_s_r & ~release_overrun_flag &
                          high_input_ok;
        low_switch_on <= low_switch_enable_bit & pin_s_r & ~release_overrun_flag &
                         low_input_ok;
      end
      sharing_boost_mode <= sys_two_r[`PLPMR_BIT_SHARE_BOOST];
      discharge_fet_on <= forced_test_active |
                          (sys_two_r[`PLPMR_BIT_DISCHARGE] & ~charge_enable_bit);
      release_stop <= storage_voltage_code < rls_uv_r;
      // Status bits are kept by their owner; masking only gates the pins
      // Reserved status positions have no mask bit and must never reach the pins
      first_interrupt_output_b <= ~|(status_one & ~mask_one_r & `PLPMR_MASK_ONE_BITS);
      second_interrupt_output_b <= ~|(status_two & ~mask_two_r & `PLPMR_MASK_TWO_BITS);
      high_current_limit_code <= high_limit_r;
      low_current_limit_code <= low_limit_r;
      buck_feedback_ref_code <= fb_ref_r;
    end
  end

endmodule : plpmr_regs

/* plpmr_defs.svh */
`ifndef PLPMR_DEFS_SVH
`define PLPMR_DEFS_SVH

`define PLPMR_OFS_MASK_ONE 8'h39
`define PLPMR_OFS_MASK_TWO 8'h3A
`define PLPMR_OFS_HIGH_LIMIT 8'h3B
`define PLPMR_OFS_LOW_LIMIT 8'h3C
`define PLPMR_OFS_RLS_UV 8'h3D
`define PLPMR_OFS_DEEP_TIME 8'h3E
`define PLPMR_OFS_SYS_TWO 8'h41
`define PLPMR_OFS_FB_REF 8'h42
`define PLPMR_OFS_DEEP_START 8'h53
`define PLPMR_OFS_STORED_INIT 8'h54
`define PLPMR_OFS_STORED_FINAL 8'h55

`define PLPMR_MASK_ONE_BITS 8'hFD
`define PLPMR_MASK_TWO_BITS 8'hFA
`define PLPMR_MASK_ONE_RST 8'hFD
`define PLPMR_MASK_TWO_RST 8'hFA
`define PLPMR_LIMIT_RST 5'h0B
`define PLPMR_RLS_UV_RST 8'h37
`define PLPMR_RLS_UV_MIN 8'h37
`define PLPMR_RLS_UV_MAX 8'hFA
`define PLPMR_SYS_TWO_BITS 8'h6C
`define PLPMR_SYS_TWO_RST 8'h48
`define PLPMR_FB_REF_RST 8'h28
`define PLPMR_FB_REF_MAX 8'hAE
`define PLPMR_CAPT_RST 8'h00

`define PLPMR_BIT_ONTOGETHER 6
`define PLPMR_BIT_SHARE_BOOST 5
`define PLPMR_BIT_RESTART 3
`define PLPMR_BIT_DISCHARGE 2

`define PLPMR_BYTE_BITS 4'h8
`define PLPMR_SLAVE_ADDR 7'h20

`endif

/* plpmr_pkg.sv */
package plpmr_pkg;
  typedef enum logic [3:0] {
    PLPMR_IDLE,
    PLPMR_ADDR,
    PLPMR_ACK_ADDR,
    PLPMR_PTR,
    PLPMR_ACK_PTR,
    PLPMR_WR,
    PLPMR_ACK_WR,
    PLPMR_RD,
    PLPMR_RD_ACK,
    PLPMR_RD_NEXT
  } plpmr_state_t;
endpackage : plpmr_pkg

/* plpmr_regs_checker.sv */
`timescale 1ns/100ps

module plpmr_regs_checker
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two,
  input wire logic [7:0] release_time,
  input wire logic [7:0] max_backup_release_timer,
  input wire logic [7:0] storage_voltage_code,
  input wire logic storage_at_uvlo,
  input wire logic forced_test_active,
  input wire logic high_input_ok,
  input wire logic first_interrupt_output_b,
  input wire logic second_interrupt_output_b,
  input wire logic release_overrun_flag,
  input wire logic discharge_fet_on,
  input wire logic high_switch_on,
  input wire logic sharing_boost_mode,
  input wire logic release_stop,
  input wire logic [4:0] high_current_limit_code,
  input wire logic [4:0] low_current_limit_code,
  input wire logic [7:0] buck_feedback_ref_code
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Inputs are held three edges so the registered outputs have caught up
  AST_FIRST_INTERRUPT_OUTPUT_QUIET: assert property (((status_one & 8'hFD) == 8'h00) [*3] |->
    first_interrupt_output_b) else $error("first interrupt low with no condition");
  AST_SECOND_INTERRUPT_OUTPUT_QUIET: assert property (((status_two & 8'hFA) == 8'h00) [*3] |->
    second_interrupt_output_b) else $error("second interrupt low with no condition");
  AST_OVERRUN_SET: assert property (release_time > max_backup_release_timer |->
    ##[1:3] release_overrun_flag) else $error("overrun flag not set");
  AST_OVERRUN_HOLD: assert property (release_overrun_flag && !storage_at_uvlo &&
    !$past(storage_at_uvlo) |=> release_overrun_flag) else $error("overrun flag lost");
  AST_LIMIT_RST: assert property ($rose(rst_b) |-> high_current_limit_code == 5'h0B &&
    low_current_limit_code == 5'h0B) else $error("limit codes wrong after reset");
  AST_FB_RST: assert property ($rose(rst_b) |-> buck_feedback_ref_code == 8'h28 &&
    !sharing_boost_mode) else $error("reference or sharing mode wrong after reset");
  AST_FB_RANGE: assert property (buck_feedback_ref_code <= 8'hAE)
    else $error("reference code above 1.27V");
  AST_FET_TEST: assert property (forced_test_active [*3] |-> discharge_fet_on)
    else $error("discharge switch off in forced test");
  AST_SWITCH_WAIT: assert property (!high_input_ok [*3] |-> !high_switch_on)
    else $error("high switch on without its input");
  // Threshold can never go below its minimum code, so this holds for any setting
  AST_RLS_STOP: assert property ((storage_voltage_code < 8'h37) [*3] |-> release_stop)
    else $error("release not stopped below minimum threshold");
endmodule : plpmr_regs_checker

bind plpmr_regs plpmr_regs_checker chk_u (.*);

/* plpmr_host.sv */
`timescale 1ns/100ps
`include "plpmr_defs.svh"

module plpmr_host
#(
  parameter int QTR = 300
)
(
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // Clock idles high between frames; data is only pulled low, the pull-up releases it
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end

  // Data moves a quarter period after the fall, never beside a clock edge
  task automatic bit_x(input logic b, output logic r);
    sda_drv = ~b;
    #QTR scl = 1'b1;
    #QTR r = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask : bit_x

  task automatic start();
    sda_drv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask : start

  task automatic stop();
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b0;
    #QTR;
  endtask : stop

  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(last, nak);
  endtask : xbyte

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
    output logic nak);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xbyte({dev, 1'b0}, 1'b1, q, n0);
    xbyte(a, 1'b1, q, n1);
    xbyte(d, 1'b1, q, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic n;
    start();
    xbyte({`PLPMR_SLAVE_ADDR, 1'b0}, 1'b1, q, n);
    xbyte(a, 1'b1, q, n);
    start();
    xbyte({`PLPMR_SLAVE_ADDR, 1'b1}, 1'b1, q, n);
    xbyte(8'hFF, 1'b1, d, n);
    stop();
  endtask : rd
endmodule : plpmr_host

/* tb_top.sv */
`timescale 1ns/100ps
`include "plpmr_defs.svh"
`define CHK(a, e) \
  begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h, expected %h", $time, (a), (e)); end end

module tb_top;
  logic clk_sys, rst_b, i2c_scl, host_drv, i2c_sda_out, i2c_sda_oe, nak;
  logic [7:0] status_one, status_two, forced_start_voltage, forced_final_voltage;
  logic [7:0] deep_test_timer, storage_voltage_code, release_time, max_backup_release_timer;
  logic forced_test_active, forced_test_done, capture_ctrl_bit, deep_test_start, deep_test_end;
  logic high_input_ok, low_input_ok, high_switch_enable_bit, low_switch_enable_bit;
  logic enable_pin, charge_enable_bit, storage_at_uvlo, first_interrupt_output_b;
  logic second_interrupt_output_b, high_switch_on, low_switch_on, sharing_boost_mode;
  logic discharge_fet_on, release_stop, release_overrun_flag;
  logic [4:0] high_current_limit_code, low_current_limit_code;
  logic [7:0] buck_feedback_ref_code, q;
  logic [7:0] m1 = 8'hFD;
  logic [7:0] m2 = 8'hFA;
  logic [15:0] rt[12] = '{16'h39FD, 16'h3AFA, 16'h3B0B, 16'h3C0B, 16'h3D37, 16'h3E00,
    16'h4148, 16'h4228, 16'h5300, 16'h5400, 16'h5500, 16'h4000};
  logic [23:0] wt[11] = '{24'h39FFFD, 24'h3AFFFA, 24'h3BFF1F, 24'h3C0101, 24'h3D0037,
    24'h3DFFFA, 24'h42FFAE, 24'h3EFF00, 24'h53AA00, 24'h405500, 24'h41FF6C};
  wire logic i2c_sda_in;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  // Open-drain line: low if either side pulls, else the pull-up wins
  assign i2c_sda_in = ~host_drv & (~i2c_sda_oe | i2c_sda_out);
  plpmr_regs dut_u (.*);
  plpmr_host host_u (.scl(i2c_scl), .sda_drv(host_drv), .sda(i2c_sda_in));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse

  task automatic rchk(input logic [15:0] e);
    host_u.rd(e[15:8], q);
    `CHK(q, e[7:0])
  endtask : rchk

  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(`PLPMR_SLAVE_ADDR, a, d, nak);
    `CHK(nak, 1'b0)
  endtask : wrc

  initial
  begin
    {status_one, status_two, forced_start_voltage, forced_final_voltage, deep_test_timer,
      storage_voltage_code, release_time, max_backup_release_timer} = '0;
    {forced_test_active, forced_test_done, capture_ctrl_bit, deep_test_start, deep_test_end,
      storage_at_uvlo, rst_b} = '0;
    {high_input_ok, low_input_ok, high_switch_enable_bit, low_switch_enable_bit, enable_pin,
      charge_enable_bit} = '1;
    repeat (6) @(posedge clk_sys);
    #5 rst_b = 1'b1;
    tick(3);
    foreach (rt[i])
      rchk(rt[i]);
    foreach (wt[i])
    begin
      wrc(wt[i][23:16], wt[i][15:8]);
      rchk({wt[i][23:16], wt[i][7:0]});
    end
    `CHK(high_current_limit_code, 5'h1F)
    `CHK(low_current_limit_code, 5'h01)
    `CHK(buck_feedback_ref_code, 8'hAE)
    host_u.wr(7'h21, 8'h3C, 8'h05, nak);
    `CHK(nak, 1'b1)
    rchk(16'h3C01);
    storage_voltage_code = 8'hF9;
    tick(4);
    `CHK(release_stop, 1'b1)
    storage_voltage_code = 8'hFA;
    tick(4);
    `CHK(release_stop, 1'b0)
    low_input_ok = 1'b0;
    charge_enable_bit = 1'b0;
    tick(4);
    `CHK(sharing_boost_mode, 1'b1)
    `CHK(discharge_fet_on, 1'b1)
    `CHK(high_switch_on, 1'b0)
    `CHK(low_switch_on, 1'b0)
    wrc(8'h41, 8'h68);
    tick(4);
    `CHK(discharge_fet_on, 1'b0)
    release_time = 8'h10;
    tick(2);
    release_time = 8'h00;
    storage_at_uvlo = 1'b1;
    tick(4);
    `CHK(release_overrun_flag, 1'b1)
    high_switch_enable_bit = 1'b0;
    tick(4);
    `CHK(release_overrun_flag, 1'b0)
    high_switch_enable_bit = 1'b1;
    release_time = 8'h10;
    tick(2);
    release_time = 8'h00;
    wrc(8'h41, 8'h00);
    forced_test_active = 1'b1;
    tick(4);
    `CHK(release_overrun_flag, 1'b0)
    `CHK(high_switch_on, 1'b1)
    `CHK(sharing_boost_mode, 1'b0)
    `CHK(discharge_fet_on, 1'b1)
    `CHK(low_switch_on, 1'b0)
    low_input_ok = 1'b1;
    high_input_ok = 1'b0;
    tick(4);
    `CHK(high_switch_on, 1'b0)
    `CHK(low_switch_on, 1'b1)
    high_input_ok = 1'b1;
    tick(4);
    `CHK(high_switch_on, 1'b1)
    wrc(8'h39, 8'h00);
    wrc(8'h3A, 8'h00);
    for (int b = 0; b < 8; b++)
    begin
      status_one = 8'h01 << b;
      status_two = 8'h01 << b;
      tick(4);
      `CHK(first_interrupt_output_b, ~m1[b])
      `CHK(second_interrupt_output_b, ~m2[b])
    end
    wrc(8'h39, 8'hFF);
    wrc(8'h3A, 8'hFF);
    status_one = 8'hFF;
    status_two = 8'hFF;
    tick(4);
    `CHK(first_interrupt_output_b, 1'b1)
    `CHK(second_interrupt_output_b, 1'b1)
    storage_voltage_code = 8'h5A;
    deep_test_timer = 8'h3C;
    forced_start_voltage = 8'h11;
    forced_final_voltage = 8'h22;
    pulse(deep_test_start);
    pulse(deep_test_end);
    pulse(forced_test_done);
    forced_start_voltage = 8'h33;
    forced_final_voltage = 8'h44;
    pulse(forced_test_done);
    rchk(16'h535A);
    rchk(16'h3E3C);
    rchk(16'h5411);
    rchk(16'h5522);
    pulse(capture_ctrl_bit);
    rchk(16'h5433);
    rchk(16'h5544);
    end_of_test();
  end
endmodule : tb_top
